// [hw/cpw_unit.sv]
// module: compare and pwm unit with avalon-mm register slave
//
// The Avalon-MM register port was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module cpw_unit
   import cpw_pkg::*;
(
   // clock and reset
   input  wire logic              clk_sys,
   input  wire logic              reset,
   // avalon-mm slave
   input  wire logic [ADDR_W-1:0] avs_address,
   input  wire logic              avs_read,
   input  wire logic              avs_write,
   input  wire logic [31:0]       avs_writedata,
   output logic [31:0]            avs_readdata,
   output logic                   avs_waitrequest,
   // shared output pin
   output logic                   unit_output_pin,
   output logic                   shared_pin_oe,
   // system events
   output logic                   adc_start,
   output logic                   irq
);
   // bus group
   cpw_bus_state_type bus_r;
   cpw_bus_state_type bus_nxt;
   logic [31:0]       rdata_r;
   logic [31:0]       rdata_nxt;
   logic              wreq_r;
   logic              wreq_nxt;
   logic [7:0]        word;
   logic [7:0]        rd_val;
   logic              acc_wr;
   logic [7:0]        wd;

   // software registers
   logic [7:0]  flags_r;
   logic [7:0]  flags_nxt;
   logic [7:0]  en_r;
   logic [7:0]  en_nxt;
   logic [7:0]  timer1_control_r;
   logic [7:0]  timer1_control_nxt;
   logic [7:0]  t2con_r;
   logic [7:0]  t2con_nxt;
   logic [7:0]  ccpl_r;
   logic [7:0]  ccpl_nxt;
   logic [7:0]  ccph_r;
   logic [7:0]  ccph_nxt;
   logic [7:0]  ctl_r;
   logic [7:0]  ctl_nxt;
   logic [7:0]  adc_r;
   logic [7:0]  adc_nxt;
   logic [7:0]  dir_r;
   logic [7:0]  dir_nxt;
   logic [7:0]  per_r;
   logic [7:0]  per_nxt;

   // core state
   logic [15:0] timer1_count_r;
   logic [15:0] timer1_count_nxt;
   logic [2:0]  pre1_r;
   logic [2:0]  pre1_nxt;
   logic [1:0]  q_r;
   logic [1:0]  q_nxt;
   logic        mprev_r;
   logic        mprev_nxt;
   logic        pin_r;
   logic        pin_nxt;
   logic        oe_r;
   logic        oe_nxt;
   logic        adst_r;
   logic        adst_nxt;
   logic        irq_r;
   logic        irq_nxt;
   logic [1:0]  dlat_r;
   logic [1:0]  dlat_nxt;
   logic        wrap_d_r;
   logic        wrap_d_nxt;

   // combinational terms
   logic        inst_en;
   logic        t1_tick;
   logic        cmp_hit;
   logic        cmp_evt;
   logic        spec_evt;
   logic        pwm_on;
   logic        ctl_zero;
   logic [9:0]  duty_new;
   logic [7:0]  t2_cnt;
   logic [1:0]  t2_ext;
   logic        t2_wrap;

   // register hit for an accepted write
   function automatic logic wr_hit(input logic [7:0] w, input logic [7:0] idx, input logic a);
      return a && (w == idx);
   endfunction

   assign word = avs_address[ADDR_W-1:2];
   assign wd = avs_writedata[7:0];
   assign acc_wr = (bus_r == BUS_ACK) && avs_write;
   assign inst_en = (q_r == Q_LAST);

   // pwm time base
   cpw_timer2 u_timer2_count (
      .clk_sys  (clk_sys),
      .reset    (reset),
      .inst_en  (inst_en),
      .q_phase  (q_r),
      .run      (t2con_r[T2_ON]),
      .ckps     (t2con_r[T2_CKPS+:2]),
      .period   (per_r),
      .load     (wr_hit(word, IDX_T2, acc_wr)),
      .load_val (wd),
      .count    (t2_cnt),
      .ext      (t2_ext),
      .wrap     (t2_wrap)
   );

   // read mux; unmapped words read zero
   always_comb begin
      case (word)
         IDX_FLAGS: rd_val = flags_r;
         IDX_T1L: rd_val = timer1_count_r[7:0];
         IDX_T1H: rd_val = timer1_count_r[15:8];
         IDX_TIMER1_CONTROL: rd_val = timer1_control_r;
         IDX_T2: rd_val = t2_cnt;
         IDX_T2CON: rd_val = t2con_r;
         IDX_CCPL: rd_val = ccpl_r;
         IDX_CCPH: rd_val = ccph_r;
         IDX_CTL: rd_val = ctl_r;
         IDX_ADC: rd_val = adc_r;
         IDX_DIR: rd_val = dir_r;
         IDX_EN: rd_val = en_r;
         IDX_PER: rd_val = per_r;
         default: rd_val = RST_ZERO;
      endcase
   end

   // one wait state: request seen, then waitrequest drops for one cycle
   always_comb begin
      bus_nxt = bus_r;
      wreq_nxt = 1'b1;
      rdata_nxt = rdata_r;
      case (bus_r)
         BUS_IDLE: begin
            if (avs_read || avs_write) begin
               bus_nxt = BUS_ACK;
               wreq_nxt = 1'b0;
               rdata_nxt = {24'h000000, rd_val};
            end
         end
         BUS_ACK: bus_nxt = BUS_IDLE;
         default: bus_nxt = BUS_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         bus_r <= BUS_IDLE;
         wreq_r <= 1'b1;
         rdata_r <= 32'h00000000;
      end else begin
         bus_r <= bus_nxt;
         wreq_r <= wreq_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   // timers, compare, pwm, flags and software registers
   always_comb begin
      flags_nxt = flags_r;
      en_nxt = en_r;
      timer1_control_nxt = timer1_control_r;
      t2con_nxt = t2con_r;
      ccpl_nxt = ccpl_r;
      ccph_nxt = ccph_r;
      ctl_nxt = ctl_r;
      adc_nxt = adc_r;
      dir_nxt = dir_r;
      per_nxt = per_r;
      timer1_count_nxt = timer1_count_r;
      pre1_nxt = pre1_r;
      dlat_nxt = dlat_r;
      pin_nxt = pin_r;
      t1_tick = 1'b0;
      q_nxt = q_r + 2'h1;
      pwm_on = (ctl_r[3:2] == GRP_PWM);
      duty_new = {ccpl_r, ctl_r[CTL_DLO+:2]};
      ctl_zero = wr_hit(word, IDX_CTL, acc_wr) && (wd == RST_ZERO);
      // timer1 prescaler 1, 2, 4 or 8 instruction cycles
      if (inst_en && timer1_control_r[T1_ON]) begin
         pre1_nxt = pre1_r + 3'h1;
         case (timer1_control_r[T1_CKPS+:2])
            2'h0: t1_tick = 1'b1;
            2'h1: t1_tick = pre1_r[0];
            2'h2: t1_tick = &pre1_r[1:0];
            default: t1_tick = &pre1_r;
         endcase
      end
      // edge of equality so a stalled timer does not refire
      cmp_hit = (ctl_r[3:2] == GRP_CMP) && (timer1_count_r == {ccph_r, ccpl_r});
      cmp_evt = cmp_hit && !mprev_r;
      mprev_nxt = cmp_hit;
      spec_evt = cmp_evt && (ctl_r[3:0] == MODE_SPEC);
      adst_nxt = spec_evt && adc_r[ADC_EN];
      // timer1: software write beats the trigger clear beats the count
      if (wr_hit(word, IDX_T1L, acc_wr))
         timer1_count_nxt[7:0] = wd;
      else if (wr_hit(word, IDX_T1H, acc_wr))
         timer1_count_nxt[15:8] = wd;
      else if (spec_evt)
         timer1_count_nxt = RST_T1;
      else if (t1_tick)
         timer1_count_nxt = timer1_count_r + 16'h0001;
      // plain register writes
      if (wr_hit(word, IDX_EN, acc_wr))
         en_nxt = wd & FLAG_MASK;
      if (wr_hit(word, IDX_TIMER1_CONTROL, acc_wr))
         timer1_control_nxt = wd & TIMER1_CONTROL_MASK;
      if (wr_hit(word, IDX_T2CON, acc_wr))
         t2con_nxt = wd & T2CON_MASK;
      if (wr_hit(word, IDX_ADC, acc_wr))
         adc_nxt = wd & ADC_MASK;
      if (wr_hit(word, IDX_DIR, acc_wr))
         dir_nxt = wd;
      if (wr_hit(word, IDX_PER, acc_wr))
         per_nxt = wd;
      if (wr_hit(word, IDX_CCPL, acc_wr))
         ccpl_nxt = wd;
      if (wr_hit(word, IDX_CTL, acc_wr))
         ctl_nxt = wd & CTL_MASK;
      // the duty buffer only moves at a period match in pwm mode
      if (wr_hit(word, IDX_CCPH, acc_wr) && !pwm_on)
         ccph_nxt = wd;
      if (pwm_on && t2_wrap) begin
         ccph_nxt = duty_new[9:2];
         dlat_nxt = duty_new[1:0];
      end
      wrap_d_nxt = pwm_on && t2_wrap;
      // sticky flags: write one to clear, a new event wins
      if (wr_hit(word, IDX_FLAGS, acc_wr))
         flags_nxt = flags_r & ~wd;
      flags_nxt[BIT_MATCH] = flags_nxt[BIT_MATCH] | cmp_evt;
      flags_nxt[BIT_T2IF] = flags_nxt[BIT_T2IF] | t2_wrap;
      flags_nxt[BIT_T1IF] = flags_nxt[BIT_T1IF] | (t1_tick && timer1_count_r == T1_MAX);
      flags_nxt = flags_nxt & FLAG_MASK;
      irq_nxt = |(flags_r & en_r);
      // output latch; zero control write wins; the set is taken one clock after the wrap, the clear at the duty match itself
      if (ctl_zero)
         pin_nxt = 1'b0;
      else if (cmp_evt) begin
         case (ctl_r[3:0])
            MODE_SET: pin_nxt = 1'b1;
            MODE_CLR: pin_nxt = 1'b0;
            default: pin_nxt = pin_r;
         endcase
      end else if (pwm_on && wrap_d_r)
         pin_nxt = ({ccph_r, dlat_r} != 10'h000);
      else if (pwm_on && ({t2_cnt, t2_ext} == {ccph_r, dlat_r}))
         pin_nxt = 1'b0;
      // pin drives only while its direction bit says output
      oe_nxt = !dir_r[PIN_DIR];
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         flags_r <= RST_ZERO;
         en_r <= RST_ZERO;
         timer1_control_r <= RST_ZERO;
         t2con_r <= RST_ZERO;
         ccpl_r <= RST_ZERO;
         ccph_r <= RST_ZERO;
         ctl_r <= RST_ZERO;
         adc_r <= RST_ZERO;
         dir_r <= RST_DIR;
         per_r <= RST_PER;
         timer1_count_r <= RST_T1;
         pre1_r <= 3'h0;
         q_r <= 2'h0;
         mprev_r <= 1'b0;
         pin_r <= 1'b0;
         oe_r <= 1'b0;
         adst_r <= 1'b0;
         irq_r <= 1'b0;
         dlat_r <= 2'h0;
         wrap_d_r <= 1'b0;
      end else begin
         flags_r <= flags_nxt;
         en_r <= en_nxt;
         timer1_control_r <= timer1_control_nxt;
         t2con_r <= t2con_nxt;
         ccpl_r <= ccpl_nxt;
         ccph_r <= ccph_nxt;
         ctl_r <= ctl_nxt;
         adc_r <= adc_nxt;
         dir_r <= dir_nxt;
         per_r <= per_nxt;
         timer1_count_r <= timer1_count_nxt;
         pre1_r <= pre1_nxt;
         q_r <= q_nxt;
         mprev_r <= mprev_nxt;
         pin_r <= pin_nxt;
         oe_r <= oe_nxt;
         adst_r <= adst_nxt;
         irq_r <= irq_nxt;
         dlat_r <= dlat_nxt;
         wrap_d_r <= wrap_d_nxt;
      end
   end

   // outputs straight from flops
   assign avs_readdata = rdata_r;
   assign avs_waitrequest = wreq_r;
   assign unit_output_pin = pin_r;
   assign shared_pin_oe = oe_r;
   assign adc_start = adst_r;
   assign irq = irq_r;

   // checks on the compare and pwm behaviour
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (reset);

   cmp_set_a: assert property (cmp_evt && ctl_r[3:0] == MODE_SET && !ctl_zero |=> pin_r)
      else $error("compare set did not drive pin high");
   cmp_clr_a: assert property (cmp_evt && ctl_r[3:0] == MODE_CLR |=> !pin_r)
      else $error("compare clear did not drive pin low");
   match_flag_a: assert property (cmp_evt |=> flags_r[BIT_MATCH])
      else $error("match flag not set on compare match");
   ctl_zero_a: assert property (ctl_zero |=> !pin_r && ctl_r == RST_ZERO)
      else $error("zero control write left latch high");
   swi_pin_a: assert property (cmp_evt && ctl_r[3:0] == MODE_SWI && !ctl_zero
      |=> $stable(pin_r)) else $error("software interrupt mode moved the pin");
   spec_clr_a: assert property (spec_evt && !acc_wr |=> timer1_count_r == RST_T1)
      else $error("special event did not clear timer1");
   spec_adc_a: assert property (spec_evt && adc_r[ADC_EN] |=> adc_start ##1 !adc_start)
      else $error("special event a/d start not a single pulse");
   duty_load_a: assert property (pwm_on && t2_wrap
      |=> {ccph_r, dlat_r} == $past(duty_new)) else $error("duty not latched at period match");
   pwm_set_a: assert property (pwm_on && wrap_d_r && !ctl_zero |=> pin_r ==
      ($past({ccph_r, dlat_r}) != 10'h000)) else $error("pin not set at period start");
   pwm_clear_a: assert property (pwm_on && !t2_wrap && !ctl_zero &&
      {t2_cnt, t2_ext} == {ccph_r, dlat_r} |=> !pin_r) else $error("duty match left pin high");
   duty_ro_a: assert property (pwm_on && !t2_wrap |=> $stable(ccph_r))
      else $error("duty buffer changed outside a period match");
   match_once_a: assert property (cmp_evt |=> !cmp_evt [*2])
      else $error("compare match fired twice");
   irq_level_a: assert property (flags_r[BIT_MATCH] && en_r[BIT_MATCH] |=> irq)
      else $error("enabled match flag did not raise interrupt");
   irq_quiet_a: assert property ((flags_r & en_r) == RST_ZERO |=> !irq)
      else $error("interrupt raised with no enabled flag");
endmodule
`default_nettype wire

// [hw/cpw_pkg.sv]
// package: register indexes, field positions, reset values and mode codes
package cpw_pkg;
   // avalon byte address width; byte address is four times the index
   localparam int ADDR_W = 10;
   // register indexes
   localparam logic [7:0] IDX_FLAGS = 8'h0C;
   localparam logic [7:0] IDX_T1L   = 8'h0E;
   localparam logic [7:0] IDX_T1H   = 8'h0F;
   localparam logic [7:0] IDX_TIMER1_CONTROL = 8'h10;
   localparam logic [7:0] IDX_T2    = 8'h11;
   localparam logic [7:0] IDX_T2CON = 8'h12;
   localparam logic [7:0] IDX_CCPL  = 8'h15;
   localparam logic [7:0] IDX_CCPH  = 8'h16;
   localparam logic [7:0] IDX_CTL   = 8'h17;
   localparam logic [7:0] IDX_ADC   = 8'h1F;
   localparam logic [7:0] IDX_DIR   = 8'h87;
   localparam logic [7:0] IDX_EN    = 8'h8C;
   localparam logic [7:0] IDX_PER   = 8'h92;
   // field positions
   localparam int BIT_T1IF  = 0;
   localparam int BIT_T2IF  = 1;
   localparam int BIT_MATCH = 2;
   localparam int T1_ON     = 0;
   localparam int T1_CKPS   = 4;
   localparam int T2_ON     = 2;
   localparam int T2_CKPS   = 0;
   localparam int CTL_DLO   = 4;
   localparam int ADC_EN    = 0;
   localparam int PIN_DIR   = 2;
   // implemented bits of each register
   localparam logic [7:0] FLAG_MASK  = 8'h07;
   localparam logic [7:0] TIMER1_CONTROL_MASK = 8'h3F;
   localparam logic [7:0] T2CON_MASK = 8'h07;
   localparam logic [7:0] CTL_MASK   = 8'h3F;
   localparam logic [7:0] ADC_MASK   = 8'h01;
   // values after reset
   localparam logic [7:0]  RST_ZERO = 8'h00;
   localparam logic [7:0]  RST_DIR  = 8'hFF;
   localparam logic [7:0]  RST_PER  = 8'hFF;
   localparam logic [15:0] RST_T1   = 16'h0000;
   localparam logic [3:0]  RST_PRE  = 4'h0;
   // counts
   localparam logic [1:0]  Q_LAST = 2'h3;
   localparam logic [3:0]  PRE16  = 4'hF;
   localparam logic [15:0] T1_MAX = 16'hFFFF;
   // mode field codes
   localparam logic [3:0] MODE_SET  = 4'h8;
   localparam logic [3:0] MODE_CLR  = 4'h9;
   localparam logic [3:0] MODE_SWI  = 4'hA;
   localparam logic [3:0] MODE_SPEC = 4'hB;
   localparam logic [1:0] GRP_CMP   = 2'h2;
   localparam logic [1:0] GRP_PWM   = 2'h3;
   // bus handshake states
   typedef enum logic {BUS_IDLE, BUS_ACK} cpw_bus_state_type;
endpackage

// [hw/cpw_timer2.sv]
// module: 8-bit pwm time base with prescaler and 2-bit fine extension
`timescale 1ns/100ps
`default_nettype none
module cpw_timer2
   import cpw_pkg::*;
(
   // clock and reset
   input  wire logic       clk_sys,
   input  wire logic       reset,
   // timing and control
   input  wire logic       inst_en,
   input  wire logic [1:0] q_phase,
   input  wire logic       run,
   input  wire logic [1:0] ckps,
   input  wire logic [7:0] period,
   // software load
   input  wire logic       load,
   input  wire logic [7:0] load_val,
   // time base state
   output logic [7:0]      count,
   output logic [1:0]      ext,
   output logic            wrap
);
   logic [7:0] cnt_r;
   logic [7:0] cnt_nxt;
   logic [3:0] pre_r;
   logic [3:0] pre_nxt;
   logic       tick;

   // prescaled increment; the count clears to zero on the tick that matches the period
   always_comb begin
      pre_nxt = pre_r;
      cnt_nxt = cnt_r;
      tick = 1'b0;
      if (inst_en && run) begin
         pre_nxt = pre_r + 4'h1;
         case (ckps)
            2'h0: tick = 1'b1;
            2'h1: tick = (pre_r[1:0] == Q_LAST);
            default: tick = (pre_r == PRE16);
         endcase
      end
      wrap = tick && (cnt_r == period);
      if (load)
         cnt_nxt = load_val;
      else if (wrap)
         cnt_nxt = RST_ZERO;
      else if (tick)
         cnt_nxt = cnt_r + 8'h01;
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         cnt_r <= RST_ZERO;
         pre_r <= RST_PRE;
      end else begin
         cnt_r <= cnt_nxt;
         pre_r <= pre_nxt;
      end
   end

   // fine bits: q phase at 1:1, else the prescaler bits below the count
   assign ext = (ckps == 2'h0) ? q_phase : (ckps == 2'h1) ? pre_r[1:0] : pre_r[3:2];
   assign count = cnt_r;
endmodule
`default_nettype wire

// [tb/cpw_pin_load.sv]
// file: external load on the compare/pwm pin, measuring high time and period
`timescale 1ns/100ps
`default_nettype none
module cpw_pin_load (
   // clock
   input  wire logic clk_sys,
   // pin as driven by the unit
   input  wire logic pin,
   input  wire logic oe,
   // measurements
   output var int    hi_total,
   output var int    per_len
);
   int   since_rise;
   logic pin_d;
   initial begin
      hi_total = 0;
      per_len = 0;
      since_rise = 0;
      pin_d = 1'b0;
   end
   // only a driven pin counts toward the high time; the period is timed from pin rises whether driven or not
   always @(posedge clk_sys) begin
      if (oe === 1'b1 && pin === 1'b1) hi_total <= hi_total + 1;
      if (pin === 1'b1 && pin_d !== 1'b1) begin
         per_len <= since_rise;
         since_rise <= 1;
      end else begin
         since_rise <= since_rise + 1;
      end
      pin_d <= pin;
   end
endmodule
`default_nettype wire

// [tb/cpw_unit_bench.sv]
// file: self-checking bench for the compare and pwm unit
`timescale 1ns/100ps
`default_nettype none
module cpw_unit_bench;
   import cpw_pkg::*;
   logic              clk_sys = 1'b0;
   logic              reset = 1'b1;
   logic [ADDR_W-1:0] avs_address = '0;
   logic              avs_read = 1'b0;
   logic              avs_write = 1'b0;
   logic [31:0]       avs_writedata = 32'h00000000;
   logic [31:0]       avs_readdata;
   logic              avs_waitrequest;
   logic              unit_output_pin;
   logic              shared_pin_oe;
   logic              adc_start;
   logic              irq;
   int                err_count = 0;
   int                n_tests = 0;
   int                adc_cnt = 0;
   int                hi_total;
   int                per_len;
   int                i;
   int                h0;
   logic [31:0]       rd;
   // compare rows: mode, pin after the match, pin checked, a/d start expected
   typedef struct {logic [3:0] mode; logic pin; logic pin_chk; logic adc;} cpw_crow_type;
   // pwm rows: duty byte, duty low bits, high clocks per 40-clock period
   typedef struct {logic [7:0] dh; logic [1:0] dl; int hi;} cpw_prow_type;
   cpw_crow_type crow [4] = '{'{MODE_SET, 1'b1, 1'b1, 1'b0}, '{MODE_SWI, 1'b1, 1'b1, 1'b0},
                              '{MODE_CLR, 1'b0, 1'b1, 1'b0}, '{MODE_SPEC, 1'b0, 1'b0, 1'b1}};
   cpw_prow_type prow [4] = '{'{8'h03, 2'h2, 14}, '{8'h00, 2'h0, 0},
                              '{8'h09, 2'h3, 39}, '{8'h0A, 2'h0, 40}};
   logic [7:0]   ridx [6] = '{IDX_FLAGS, IDX_TIMER1_CONTROL, IDX_CTL, IDX_EN, IDX_DIR, IDX_PER};
   logic [7:0]   rval [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF};

   cpw_unit cpw_unit_inst (.clk_sys(clk_sys), .reset(reset), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .unit_output_pin(unit_output_pin), .shared_pin_oe(shared_pin_oe),
      .adc_start(adc_start), .irq(irq));
   cpw_pin_load cpw_pin_load_inst (.clk_sys(clk_sys), .pin(unit_output_pin),
      .oe(shared_pin_oe), .hi_total(hi_total), .per_len(per_len));

   // 20 MHz system clock
   always #25 clk_sys = ~clk_sys;
   // count a/d start pulses
   always @(posedge clk_sys) if (adc_start === 1'b1) adc_cnt <= adc_cnt + 1;

   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
         err_count++;
      end
   endtask
   // one avalon transfer; the request stands until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
      int k;
      avs_address <= {idx, 2'h0};
      avs_write <= wr;
      avs_read <= ~wr;
      avs_writedata <= {24'h000000, wd};
      for (k = 0; k < 64; k++) begin
         @(posedge clk_sys);
         if (avs_waitrequest === 1'b0) break;
      end
      if (k == 64) begin
         err_count++;
         stop_test();
      end
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge clk_sys);
   endtask
   task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
      bus(1'b1, idx, wd);
   endtask
   task automatic rc(input logic [7:0] idx, input logic [7:0] exp);
      bus(1'b0, idx, 8'h00);
      chk(rd, {24'h000000, exp});
   endtask
   // bounded wait for the interrupt line to reach a level
   task automatic wait_irq(input logic lvl);
      int k;
      for (k = 0; k < 400; k++) begin
         @(posedge clk_sys);
         if (irq === lvl) break;
      end
      if (k == 400) begin
         err_count++;
         stop_test();
      end
   endtask

   initial begin
      repeat (10) @(posedge clk_sys);
      reset <= 1'b0;
      @(posedge clk_sys);
      wr(IDX_DIR, 8'hFB);
      @(negedge clk_sys);
      chk(32'(shared_pin_oe), 32'h1);
      @(posedge clk_sys);
      wr(IDX_EN, 8'h04);
      wr(IDX_ADC, 8'h01);
      wr(IDX_CCPL, 8'h05);
      wr(IDX_CCPH, 8'h00);
      // compare modes, timer1 counting from zero up to the compare value 5
      for (i = 0; i < 4; i++) begin
         wr(IDX_TIMER1_CONTROL, 8'h00);
         wr(IDX_T1L, 8'h00);
         wr(IDX_T1H, 8'h00);
         wr(IDX_CTL, {4'h0, crow[i].mode});
         h0 = adc_cnt;
         wr(IDX_TIMER1_CONTROL, 8'h01);
         wait_irq(1'b1);
         wr(IDX_TIMER1_CONTROL, 8'h00);
         @(negedge clk_sys);
         if (crow[i].pin_chk) chk(32'(unit_output_pin), 32'(crow[i].pin));
         chk(32'(adc_cnt != h0), 32'(crow[i].adc));
         @(posedge clk_sys);
         rc(IDX_FLAGS, 8'h04);
         bus(1'b0, IDX_T1L, 8'h00);
         chk(32'(rd < 32'h5), 32'(crow[i].adc));
         wr(IDX_FLAGS, 8'h04);
         rc(IDX_FLAGS, 8'h00);
         $display("compare row %0d done", i);
      end
      // pwm: period register 9 gives 40 clocks
      wr(IDX_PER, 8'h09);
      wr(IDX_T2CON, 8'h04);
      for (i = 0; i < 4; i++) begin
         wr(IDX_CCPL, prow[i].dh);
         wr(IDX_CTL, {2'h0, prow[i].dl, 4'hC});
         repeat (100) @(posedge clk_sys);
         h0 = hi_total;
         repeat (80) @(posedge clk_sys);
         chk(hi_total - h0, 2 * prow[i].hi);
         wr(IDX_CCPH, 8'h55);
         rc(IDX_CCPH, prow[i].dh);
         $display("pwm row %0d done", i);
      end
      chk(per_len, 40);
      // clearing the control register drops a pin held high
      wr(IDX_CTL, 8'h00);
      @(negedge clk_sys);
      chk(32'(unit_output_pin), 32'h0);
      @(posedge clk_sys);
      h0 = hi_total;
      repeat (80) @(posedge clk_sys);
      chk(hi_total - h0, 0);
      // stop timer2 and drop its period flags, or they would show up beside the match flag
      wr(IDX_T2CON, 8'h00);
      wr(IDX_FLAGS, 8'h07);
      $display("control clear done");
      // timer held on the compare value: one match only, masked then enabled
      wr(IDX_EN, 8'h00);
      // pwm left its duty in the compare pair; put the compare value back to 5
      wr(IDX_CCPH, 8'h00);
      wr(IDX_CCPL, 8'h05);
      wr(IDX_CTL, {4'h0, MODE_SWI});
      wr(IDX_T1L, 8'h05);
      rc(IDX_FLAGS, 8'h04);
      chk(32'(irq), 32'h0);
      wr(IDX_EN, 8'h04);
      wait_irq(1'b1);
      wr(IDX_FLAGS, 8'h04);
      repeat (8) @(posedge clk_sys);
      rc(IDX_FLAGS, 8'h00);
      chk(32'(irq), 32'h0);
      wr(8'h40, 8'hAA);
      rc(8'h40, 8'h00);
      $display("single match done");
      // second reset in mid-run, then reset values
      reset <= 1'b1;
      repeat (10) @(posedge clk_sys);
      reset <= 1'b0;
      @(posedge clk_sys);
      @(negedge clk_sys);
      chk({30'h0, shared_pin_oe, unit_output_pin}, 32'h0);
      @(posedge clk_sys);
      for (i = 0; i < 6; i++) rc(ridx[i], rval[i]);
      $display("reset values done");
      stop_test();
   end
endmodule
`default_nettype wire
